//--- i2cme_top.sv
// Purpose: Two-wire bus master running write, read and stop commands on a data memory array
// Assumes: Link clock drives the bit engine; user side and memory run on the core clock
// Notes: Commands, byte fetches, byte stores and completion cross by toggle handshakes
// Contract
// - The block is the only master on the bus and clocks it at 100 kHz.
// - A write opens with a start, then the 7-bit target address and a low direction bit.
// - A write whose address is not acknowledged gets a stop and sends no data.
// - After an acknowledged address, count bytes go out in order from consecutive memory entries.
// - A write whose bytes are all acknowledged ends without a stop, so a read may follow as a repeated start.
// - The stop command issues a stop condition to close a held bus.
// - The acknowledge is checked and the status reads 1 when it came and 0 when it did not.
// - A read opens with a start, then the 7-bit target address and a high direction bit.
// - A read whose address is not acknowledged gets a stop and ends.
// - The master clocks in bits from the slave and acknowledges every byte but the last.
// - The last read byte is not acknowledged and a stop follows on its own.
// - Read bytes land in entries from the start index up to start plus count minus one.
`timescale 1ns/10ps
module i2cme_top
    import i2cme_pkg::*;
#(
    parameter int unsigned QUARTER = QUARTER_CYC
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_link_clk,
    input wire logic i_cmd_valid,
    input wire i2cme_cmd_t i_cmd,
    output logic o_busy,
    output logic o_done,
    output logic o_ack_status,
    input wire logic i_mem_we,
    input wire logic [MEM_AW-1:0] i_mem_index,
    input wire logic [7:0] i_mem_wdata,
    output logic [7:0] o_mem_rdata,
    input wire logic i_scl_i,
    output logic o_scl_o,
    output logic o_scl_oe,
    input wire logic i_sda_i,
    output logic o_sda_o,
    output logic o_sda_oe
);
    localparam int unsigned QC_W = (QUARTER > 1) ? $clog2(QUARTER) : 1;
    localparam logic [QC_W-1:0] Q_LAST = QC_W'(QUARTER - 1);
    localparam logic [CNT_W-1:0] ONE_LEFT = CNT_W'(1);

    // Core domain
    logic busy_reg, done_reg, status_reg, cmd_tgl_reg, done_seen_reg, xfer_ack_reg;
    i2cme_cmd_t cmd_reg;
    logic [7:0] mem [MEM_DEPTH];
    logic [7:0] rdata_reg, xfer_rdata_reg;
    logic [1:0] core_s;
    // Link domain
    i2cme_state_t state_reg;
    i2cme_phase_t phase_reg;
    i2cme_op_t lop_reg;
    i2cme_xfer_t xfer_reg;
    logic [1:0] qidx_reg;
    logic [QC_W-1:0] qcnt_reg;
    logic [3:0] bitcnt_reg;
    logic [7:0] shift_reg;
    logic [CNT_W-1:0] remain_reg;
    logic [MEM_AW-1:0] idx_reg;
    logic scl_oe_reg, sda_oe_reg, ack_reg, lstatus_reg, cmd_seen_reg, xfer_tgl_reg, done_tgl_reg;
    logic [3:0] link_s;

    i2cme_sync #(.WIDTH(2)) u_core_sync (
        .i_clk(i_core_clk),
        .i_rst(i_rst),
        .i_async({done_tgl_reg, xfer_tgl_reg}),
        .o_sync(core_s)
    );

    i2cme_sync #(.WIDTH(4)) u_link_sync (
        .i_clk(i_link_clk),
        .i_rst(i_rst),
        .i_async({cmd_tgl_reg, xfer_ack_reg, i_scl_i, i_sda_i}),
        .o_sync(link_s)
    );

    wire accept = i_cmd_valid && !busy_reg;
    wire done_evt = core_s[1] != done_seen_reg;
    wire xfer_evt = core_s[0] != xfer_ack_reg;
    wire store_en = xfer_evt && xfer_reg.write;
    wire mem_wr = store_en || i_mem_we;
    wire [MEM_AW-1:0] wr_index = store_en ? xfer_reg.index : i_mem_index;
    wire [7:0] wr_data = store_en ? xfer_reg.data : i_mem_wdata;

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            status_reg <= 1'b0;
            cmd_tgl_reg <= 1'b0;
            done_seen_reg <= 1'b0;
            cmd_reg <= '0;
        end
        else
        begin
            done_reg <= done_evt;
            done_seen_reg <= core_s[1];
            if (accept)
            begin
                busy_reg <= 1'b1;
                cmd_reg <= i_cmd;
                cmd_tgl_reg <= !cmd_tgl_reg;
            end
            else if (done_evt)
            begin
                busy_reg <= 1'b0;
                // A stop command leaves the last acknowledge result in place
                if (cmd_reg.op != I2CME_OP_STOP)
                    status_reg <= lstatus_reg;
            end
        end
    end

    // Engine stores win over software writes; software should write only while idle
    generate
        for (genvar g = 0; g < MEM_DEPTH; g++)
        begin : g_mem
            always_ff @(posedge i_core_clk or posedge i_rst)
            begin
                if (i_rst)
                    mem[g] <= MEM_RESET;
                else if (mem_wr && wr_index == MEM_AW'(g))
                    mem[g] <= wr_data;
            end
        end
    endgenerate

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rdata_reg <= MEM_RESET;
            xfer_rdata_reg <= MEM_RESET;
            xfer_ack_reg <= 1'b0;
        end
        else
        begin
            rdata_reg <= mem[i_mem_index];
            xfer_ack_reg <= core_s[0];
            if (xfer_evt)
                xfer_rdata_reg <= mem[xfer_reg.index];
        end
    end

    assign o_busy = busy_reg;
    assign o_done = done_reg;
    assign o_ack_status = status_reg;
    assign o_mem_rdata = rdata_reg;
    // Open drain: the line is only ever pulled low
    assign o_scl_o = 1'b0;
    assign o_sda_o = 1'b0;
    assign o_scl_oe = scl_oe_reg;
    assign o_sda_oe = sda_oe_reg;

    wire scl_s = link_s[1];
    wire sda_s = link_s[0];
    wire new_cmd = link_s[3] != cmd_seen_reg;
    wire xfer_done = link_s[2] == xfer_tgl_reg;
    wire on_bus = (state_reg == I2CME_START) || (state_reg == I2CME_BIT) || (state_reg == I2CME_STOP);
    // A slave may stretch the clock; the high quarter waits for the line to rise
    wire stretch = (qidx_reg == Q2) && !scl_s;
    wire tick = on_bus && (qcnt_reg == Q_LAST) && !stretch;
    wire byte_end = tick && (state_reg == I2CME_BIT) && (qidx_reg == Q3) && (bitcnt_reg == ACK_BIT);
    wire rd_ack_low = remain_reg > ONE_LEFT;

    always_ff @(posedge i_link_clk or posedge i_rst)
    begin
        if (i_rst)
            qcnt_reg <= '0;
        else if (!on_bus || tick)
            qcnt_reg <= '0;
        // Holding at the last count hides the line synchroniser delay, so an unstretched bit keeps its period
        else if (qcnt_reg != Q_LAST)
            qcnt_reg <= qcnt_reg + 1'b1;
    end

    always_ff @(posedge i_link_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_reg <= I2CME_IDLE;
            phase_reg <= I2CME_PH_ADDR;
            lop_reg <= I2CME_OP_WRITE;
            xfer_reg <= '0;
            qidx_reg <= Q0;
            bitcnt_reg <= '0;
            shift_reg <= '0;
            remain_reg <= '0;
            idx_reg <= '0;
            scl_oe_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            ack_reg <= 1'b0;
            lstatus_reg <= 1'b0;
            cmd_seen_reg <= 1'b0;
            xfer_tgl_reg <= 1'b0;
            done_tgl_reg <= 1'b0;
        end
        else
        begin
            if (tick)
                qidx_reg <= qidx_reg + 1'b1;
            case (state_reg)
                I2CME_IDLE:
                begin
                    if (new_cmd)
                    begin
                        cmd_seen_reg <= link_s[3];
                        lop_reg <= cmd_reg.op;
                        idx_reg <= cmd_reg.start;
                        remain_reg <= cmd_reg.count;
                        phase_reg <= I2CME_PH_ADDR;
                        bitcnt_reg <= '0;
                        shift_reg <= {cmd_reg.target_address, cmd_reg.op == I2CME_OP_READ};
                        if (cmd_reg.op == I2CME_OP_STOP)
                            state_reg <= scl_oe_reg ? I2CME_STOP : I2CME_FINISH;
                        else
                        begin
                            sda_oe_reg <= 1'b0;
                            state_reg <= I2CME_START;
                        end
                    end
                end
                I2CME_START:
                begin
                    if (tick && qidx_reg == Q0)
                        scl_oe_reg <= 1'b0;
                    if (tick && qidx_reg == Q2)
                        sda_oe_reg <= 1'b1;
                    if (tick && qidx_reg == Q3)
                    begin
                        scl_oe_reg <= 1'b1;
                        state_reg <= I2CME_BIT;
                    end
                end
                I2CME_BIT:
                begin
                    if (tick && qidx_reg == Q0)
                    begin
                        if (bitcnt_reg == ACK_BIT)
                            sda_oe_reg <= (phase_reg == I2CME_PH_RD) && rd_ack_low;
                        else
                            sda_oe_reg <= (phase_reg != I2CME_PH_RD) && !shift_reg[7];
                    end
                    if (tick && qidx_reg == Q1)
                        scl_oe_reg <= 1'b0;
                    if (tick && qidx_reg == Q2)
                    begin
                        if (bitcnt_reg == ACK_BIT)
                            ack_reg <= !sda_s;
                        else
                            shift_reg <= {shift_reg[6:0], sda_s};
                    end
                    if (tick && qidx_reg == Q3)
                    begin
                        scl_oe_reg <= 1'b1;
                        bitcnt_reg <= (bitcnt_reg == ACK_BIT) ? 4'h0 : bitcnt_reg + 1'b1;
                    end
                    if (byte_end)
                    begin
                        case (phase_reg)
                            I2CME_PH_ADDR:
                            begin
                                lstatus_reg <= ack_reg;
                                if (!ack_reg)
                                    state_reg <= I2CME_STOP;
                                else if (remain_reg == '0)
                                    state_reg <= (lop_reg == I2CME_OP_READ) ? I2CME_STOP : I2CME_FINISH;
                                else if (lop_reg == I2CME_OP_READ)
                                    phase_reg <= I2CME_PH_RD;
                                else
                                begin
                                    phase_reg <= I2CME_PH_WR;
                                    xfer_reg <= '{write: 1'b0, index: idx_reg, data: 8'h00};
                                    xfer_tgl_reg <= !xfer_tgl_reg;
                                    state_reg <= I2CME_FETCH;
                                end
                            end
                            I2CME_PH_WR:
                            begin
                                lstatus_reg <= ack_reg;
                                remain_reg <= remain_reg - 1'b1;
                                if (!ack_reg)
                                    state_reg <= I2CME_STOP;
                                else if (remain_reg == ONE_LEFT)
                                    state_reg <= I2CME_FINISH;
                                else
                                begin
                                    xfer_reg <= '{write: 1'b0, index: idx_reg + 1'b1, data: 8'h00};
                                    xfer_tgl_reg <= !xfer_tgl_reg;
                                    state_reg <= I2CME_FETCH;
                                end
                                idx_reg <= idx_reg + 1'b1;
                            end
                            default:
                            begin
                                xfer_reg <= '{write: 1'b1, index: idx_reg, data: shift_reg};
                                xfer_tgl_reg <= !xfer_tgl_reg;
                                state_reg <= I2CME_STORE;
                            end
                        endcase
                    end
                end
                I2CME_FETCH:
                begin
                    if (xfer_done)
                    begin
                        shift_reg <= xfer_rdata_reg;
                        state_reg <= I2CME_BIT;
                    end
                end
                I2CME_STORE:
                begin
                    if (xfer_done)
                    begin
                        remain_reg <= remain_reg - 1'b1;
                        idx_reg <= idx_reg + 1'b1;
                        state_reg <= (remain_reg == ONE_LEFT) ? I2CME_STOP : I2CME_BIT;
                    end
                end
                I2CME_STOP:
                begin
                    if (tick && qidx_reg == Q0)
                        sda_oe_reg <= 1'b1;
                    if (tick && qidx_reg == Q1)
                        scl_oe_reg <= 1'b0;
                    if (tick && qidx_reg == Q2)
                        sda_oe_reg <= 1'b0;
                    if (tick && qidx_reg == Q3)
                        state_reg <= I2CME_FINISH;
                end
                I2CME_FINISH:
                begin
                    done_tgl_reg <= !done_tgl_reg;
                    state_reg <= I2CME_IDLE;
                end
                default:
                    state_reg <= I2CME_IDLE;
            endcase
        end
    end

    property p_quarter_len;
        @(posedge i_link_clk) disable iff (i_rst) qcnt_reg <= Q_LAST;
    endproperty
    a_quarter_len: assert property (p_quarter_len) else $error("Quarter counter overran");
    property p_start_edge;
        @(posedge i_link_clk) disable iff (i_rst)
            (state_reg == I2CME_START && $rose(sda_oe_reg)) |-> !scl_oe_reg && !$past(scl_oe_reg);
    endproperty
    a_start_edge: assert property (p_start_edge) else $error("Start not made with clock high");
    property p_dir_bit;
        @(posedge i_link_clk) disable iff (i_rst)
            (state_reg == I2CME_BIT && phase_reg == I2CME_PH_ADDR && bitcnt_reg == 4'h7 && qidx_reg == Q2)
            |-> sda_oe_reg == (lop_reg != I2CME_OP_READ);
    endproperty
    a_dir_bit: assert property (p_dir_bit) else $error("Direction bit wrong");
    property p_nack_stop;
        @(posedge i_link_clk) disable iff (i_rst)
            (byte_end && phase_reg == I2CME_PH_ADDR && !ack_reg) |=> state_reg == I2CME_STOP && !lstatus_reg;
    endproperty
    a_nack_stop: assert property (p_nack_stop) else $error("Missing stop after address nack");
    property p_write_hold;
        @(posedge i_link_clk) disable iff (i_rst)
            (byte_end && phase_reg == I2CME_PH_WR && ack_reg && remain_reg == ONE_LEFT)
            |=> state_reg == I2CME_FINISH ##1 state_reg == I2CME_IDLE && scl_oe_reg;
    endproperty
    a_write_hold: assert property (p_write_hold) else $error("Write released the bus");
    property p_stop_cmd;
        @(posedge i_link_clk) disable iff (i_rst)
            (state_reg == I2CME_IDLE && new_cmd && cmd_reg.op == I2CME_OP_STOP && scl_oe_reg)
            |=> state_reg == I2CME_STOP;
    endproperty
    a_stop_cmd: assert property (p_stop_cmd) else $error("Stop command ignored");
    property p_rd_ack;
        @(posedge i_link_clk) disable iff (i_rst)
            (state_reg == I2CME_BIT && phase_reg == I2CME_PH_RD && bitcnt_reg == ACK_BIT && qidx_reg == Q2)
            |-> sda_oe_reg == rd_ack_low;
    endproperty
    a_rd_ack: assert property (p_rd_ack) else $error("Read acknowledge wrong");
    property p_last_stop;
        @(posedge i_link_clk) disable iff (i_rst)
            (state_reg == I2CME_STORE && xfer_done && remain_reg == ONE_LEFT) |=> state_reg == I2CME_STOP;
    endproperty
    a_last_stop: assert property (p_last_stop) else $error("No stop after last read byte");
    property p_stop_edge;
        @(posedge i_link_clk) disable iff (i_rst)
            (state_reg == I2CME_STOP && $fell(sda_oe_reg)) |-> !scl_oe_reg;
    endproperty
    a_stop_edge: assert property (p_stop_edge) else $error("Stop not made with clock high");
    property p_refuse;
        @(posedge i_core_clk) disable iff (i_rst) (busy_reg && !done_evt) |=> $stable(cmd_tgl_reg) && busy_reg;
    endproperty
    a_refuse: assert property (p_refuse) else $error("Command taken while busy");
    property p_store;
        @(posedge i_core_clk) disable iff (i_rst) store_en |=> mem[$past(xfer_reg.index)] == $past(xfer_reg.data);
    endproperty
    a_store: assert property (p_store) else $error("Read byte not stored");
    property p_status;
        @(posedge i_core_clk) disable iff (i_rst)
            (done_evt && busy_reg && cmd_reg.op != I2CME_OP_STOP) |=> o_ack_status == $past(lstatus_reg) && o_done;
    endproperty
    a_status: assert property (p_status) else $error("Status not recorded");
    c_write: cover property (@(posedge i_link_clk) disable iff (i_rst)
        byte_end && phase_reg == I2CME_PH_WR && ack_reg && remain_reg == ONE_LEFT);
    c_read: cover property (@(posedge i_link_clk) disable iff (i_rst)
        state_reg == I2CME_STORE && xfer_done && remain_reg == ONE_LEFT);
    c_nack: cover property (@(posedge i_link_clk) disable iff (i_rst)
        byte_end && phase_reg == I2CME_PH_ADDR && !ack_reg);
    c_stop: cover property (@(posedge i_link_clk) disable iff (i_rst)
        state_reg == I2CME_IDLE && new_cmd && cmd_reg.op == I2CME_OP_STOP);
endmodule

//--- i2cme_pkg.sv
// Purpose: Shared constants and types for the two-wire master command engine
// Assumes: Link clock of 80 ns clocks the bit engine; core clock of 4 ns faces the user
// Notes: Every timing count derives from the printed times
package i2cme_pkg;
    localparam int unsigned SCL_PERIOD_NS = 10000;
    localparam int unsigned LINK_PERIOD_NS = 80;
    // Longest quarter of a bus clock period, rounded down
    localparam int unsigned QUARTER_CYC = SCL_PERIOD_NS / (4 * LINK_PERIOD_NS);
    localparam int unsigned ADDR_W = 7;
    localparam int unsigned MEM_AW = 8;
    localparam int unsigned MEM_DEPTH = 256;
    localparam int unsigned CNT_W = 9;
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam logic [1:0] Q0 = 2'h0;
    localparam logic [1:0] Q1 = 2'h1;
    localparam logic [1:0] Q2 = 2'h2;
    localparam logic [1:0] Q3 = 2'h3;
    localparam logic [7:0] MEM_RESET = 8'h00;

    typedef enum logic [1:0] {
        I2CME_OP_WRITE = 2'h0,
        I2CME_OP_READ = 2'h1,
        I2CME_OP_STOP = 2'h2
    } i2cme_op_t;

    typedef enum logic [1:0] {
        I2CME_PH_ADDR = 2'h0,
        I2CME_PH_WR = 2'h1,
        I2CME_PH_RD = 2'h2
    } i2cme_phase_t;

    typedef enum logic [6:0] {
        I2CME_IDLE = 7'h01,
        I2CME_START = 7'h02,
        I2CME_BIT = 7'h04,
        I2CME_FETCH = 7'h08,
        I2CME_STORE = 7'h10,
        I2CME_STOP = 7'h20,
        I2CME_FINISH = 7'h40
    } i2cme_state_t;

    typedef struct packed {
        i2cme_op_t op;
        logic [ADDR_W-1:0] target_address;
        logic [MEM_AW-1:0] start;
        logic [CNT_W-1:0] count;
    } i2cme_cmd_t;

    typedef struct packed {
        logic write;
        logic [MEM_AW-1:0] index;
        logic [7:0] data;
    } i2cme_xfer_t;
endpackage

//--- i2cme_sync.sv
// Purpose: Two flip-flop level synchroniser for a group of independent bits
// Assumes: Each bit is a level or a toggle that changes slowly against i_clk
// Notes: The first stage feeds only the second stage
`timescale 1ns/10ps
module i2cme_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            meta_reg <= '0;
            o_sync <= '0;
        end
        else
        begin
            meta_reg <= i_async;
            o_sync <= meta_reg;
        end
    end
endmodule

//--- i2cme_slave_model.sv
// Purpose: Behavioural two-wire slave with a pointer memory
// Assumes: Both lines pulled up; first written byte loads the pointer
// Notes: A nonzero stretch holds the clock low after each fall
`timescale 1ns/10ps
module i2cme_slave_model #(
    parameter logic [6:0] ADDR = 7'h50
) (
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic [15:0] i_stretch_ns,
    output logic o_sda_pull,
    output logic o_scl_hold
);
    logic [7:0] mem [0:255];
    logic [7:0] sh;
    logic [7:0] ptr = 8'h00;
    logic [3:0] n = 4'h0;
    logic adr = 0, sel = 0, rd = 0, fst = 0, mack = 0, mack9 = 0;
    initial {o_sda_pull, o_scl_hold} = 2'h0;
    always @(negedge i_sda)
        if (i_scl)
            {n, adr, sel} = {4'h0, 2'h2};
    always @(posedge i_sda)
        if (i_scl)
            sel = 0;
    always @(posedge i_scl)
    begin
        sh = {sh[6:0], i_sda};
        mack = !i_sda;
        n = n + 4'h1;
    end
    always @(negedge i_scl)
    begin
        if (n == 4'h8)
        begin
            if (adr)
                {sel, rd, fst} = {sh[7:1] == ADDR, sh[0], 1'b1};
            else if (sel && !rd && fst)
                {ptr, fst} = {sh, 1'b0};
            else if (sel && !rd)
                {mem[ptr], ptr} = {sh, ptr + 8'h01};
            else if (sel)
                ptr = ptr + 8'h01;
            o_sda_pull = sel && (adr || !rd);
            adr = 0;
        end
        else if (n == 4'h9)
        begin
            {n, mack9} = {4'h0, mack};
            sel = sel && (!rd || mack);
            o_sda_pull = sel && rd && !mem[ptr][7];
        end
        else
            o_sda_pull = sel && rd && !mem[ptr][3'h7 - n[2:0]];
        if (i_stretch_ns != 16'h0000)
        begin
            o_scl_hold = 1;
            #(i_stretch_ns) o_scl_hold = 0;
        end
    end
endmodule

//--- i2cme_tb_top.sv
// Purpose: Self-checking bench for the two-wire command engine
// Assumes: One slave at 7'h50, lines pulled up, QUARTER shortened to 3
// Notes: Bus traffic is judged by a wire monitor and the slave memory
`timescale 1ns/10ps
module i2cme_tb_top;
    import i2cme_pkg::*;
    localparam int unsigned QTR = 3;
    logic i_core_clk = 0, i_link_clk = 0, i_rst = 1, i_cmd_valid = 0, i_mem_we = 0;
    i2cme_cmd_t i_cmd = '0;
    logic [7:0] i_mem_index = 8'h00, i_mem_wdata = 8'h00, o_mem_rdata, sh, adr_byte;
    logic [15:0] stretch = 16'h0000;
    logic o_busy, o_done, o_ack_status, o_scl_oe, o_sda_oe, sda_pull, scl_hold;
    wire scl = !(o_scl_oe || scl_hold);
    wire sda = !(o_sda_oe || sda_pull);
    int n_fail = 0, checked = 0, stops = 0, nb = 0;
    realtime t_up = 0, per = 0;
    i2cme_top #(.QUARTER(QTR)) i2cme_top_i (.i_core_clk(i_core_clk), .i_rst(i_rst),
        .i_link_clk(i_link_clk), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .o_busy(o_busy),
        .o_done(o_done), .o_ack_status(o_ack_status), .i_mem_we(i_mem_we), .i_mem_index(i_mem_index),
        .i_mem_wdata(i_mem_wdata), .o_mem_rdata(o_mem_rdata), .i_scl_i(scl), .o_scl_o(),
        .o_scl_oe(o_scl_oe), .i_sda_i(sda), .o_sda_o(), .o_sda_oe(o_sda_oe));
    i2cme_slave_model #(.ADDR(7'h50)) i2cme_slave_model_i (.i_scl(scl), .i_sda(sda),
        .i_stretch_ns(stretch), .o_sda_pull(sda_pull), .o_scl_hold(scl_hold));
    initial forever #2 i_core_clk = !i_core_clk;
    initial
    begin
        #13;
        forever #40 i_link_clk = !i_link_clk;
    end
    always @(negedge sda)
        if (scl)
            nb = 0;
    always @(posedge sda)
        if (scl)
            stops++;
    always @(posedge scl)
    begin
        if (nb == 7)
            adr_byte = {sh[6:0], sda};
        sh = {sh[6:0], sda};
        nb++;
        per = $realtime - t_up;
        t_up = $realtime;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic mem_wr(input logic [7:0] idx, input logic [7:0] d);
        {i_mem_we, i_mem_index, i_mem_wdata} = {1'b1, idx, d};
        @(posedge i_core_clk) #1 i_mem_we = 0;
        @(posedge i_core_clk) #1;
    endtask
    task automatic mem_chk(input logic [7:0] idx, input logic [7:0] exp);
        i_mem_index = idx;
        @(posedge i_core_clk) #1 check(o_mem_rdata, exp);
    endtask
    task automatic cmd(input i2cme_op_t op, input logic [6:0] a, input logic [7:0] s, input logic [8:0] c);
        int k;
        {i_cmd, i_cmd_valid} = {op, a, s, c, 1'b1};
        @(posedge i_core_clk) #1 i_cmd_valid = 0;
        check({7'h00, o_busy}, 8'h01);
        for (k = 0; k < 50000 && o_done !== 1'b1; k++)
            @(posedge i_core_clk) #1;
        check({6'h00, o_busy, o_done}, 8'h01);
    endtask
    task automatic t_nack;
        int s0 = stops;
        cmd(I2CME_OP_WRITE, 7'h11, 8'h05, 9'h003);
        check({7'h00, o_ack_status}, 8'h00);
        check(adr_byte, 8'h22);
        check(8'(stops - s0), 8'h01);
        cmd(I2CME_OP_READ, 7'h22, 8'h30, 9'h002);
        check(adr_byte, 8'h45);
        check(8'(stops - s0), 8'h02);
        mem_chk(8'h30, 8'h00);
        cmd(I2CME_OP_STOP, 7'h00, 8'h00, 9'h000);
        check(8'(stops - s0), 8'h02);
    endtask
    task automatic t_write;
        int s0;
        mem_wr(8'h05, 8'h10);
        mem_wr(8'h06, 8'ha5);
        mem_wr(8'h07, 8'h3c);
        s0 = stops;
        cmd(I2CME_OP_WRITE, 7'h50, 8'h05, 9'h003);
        check({7'h00, o_ack_status}, 8'h01);
        check(adr_byte, 8'ha0);
        check(8'(stops - s0), 8'h00);
        check(i2cme_slave_model_i.mem[8'h10], 8'ha5);
        check(i2cme_slave_model_i.mem[8'h11], 8'h3c);
        check(8'(int'(per) / 10), 8'(4 * QTR * 8));
        cmd(I2CME_OP_STOP, 7'h00, 8'h00, 9'h000);
        check(8'(stops - s0), 8'h01);
    endtask
    task automatic t_read;
        int s0;
        // Slow slave: stretching must only delay the transfer
        stretch = 16'h0320;
        i2cme_slave_model_i.mem[8'h12] = 8'h77;
        cmd(I2CME_OP_WRITE, 7'h50, 8'h05, 9'h001);
        s0 = stops;
        cmd(I2CME_OP_READ, 7'h50, 8'hfe, 9'h003);
        check(adr_byte, 8'ha1);
        check({7'h00, o_ack_status}, 8'h01);
        check(8'(stops - s0), 8'h01);
        check({7'h00, i2cme_slave_model_i.mack9}, 8'h00);
        mem_chk(8'hfe, 8'ha5);
        mem_chk(8'hff, 8'h3c);
        mem_chk(8'h00, 8'h77);
        stretch = 16'h0000;
    endtask
    task automatic give_verdict;
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        #300000;
        n_fail++;
        give_verdict;
    end
    initial
    begin
        // Reset spans link edges too, so both domains see it
        repeat (8) @(posedge i_link_clk);
        @(posedge i_core_clk) #1 i_rst = 0;
        @(posedge i_core_clk) #1;
        check({5'h00, o_busy, o_scl_oe, o_sda_oe}, 8'h00);
        t_nack;
        t_write;
        t_read;
        give_verdict;
    end
endmodule
